// ---- logic/pmcc_consts.vh ----
// Purpose: shared constants of the power management clock controller
// Assumes: included by every design file of the block
// Notes: definitions only
`ifndef PMCC_CONSTS_VH
`define PMCC_CONSTS_VH

// clock source select codes
`define PMCC_CSS_SLOW 2'h0
`define PMCC_CSS_MAIN 2'h1
`define PMCC_CSS_PLL 2'h3

// system clock word bit positions
`define PMCC_SYS_PROC 0
`define PMCC_SYS_USB 7
`define PMCC_SYS_PCK0 8
`define PMCC_SYS_W 11

// reset values
`define PMCC_PRESCALE_FIELD_RST 3'h0
`define PMCC_CSS_RST 2'h0
`define PMCC_DIV_RST 8'h00
`define PMCC_MUL_RST 11'h000
`define PMCC_USB_DIVIDER_FIELD_RST 2'h0

// oscillator start-up ticks every 8 slow clock cycles
`define PMCC_OSC_PRE_LAST 3'h7
// frequency measurement window in slow clock periods
`define PMCC_MEAS_PERIODS 5'h10

// prescale codes run 0..6, i.e. divide by 1..64
`define PMCC_PRESCALE_FIELD_MAX 3'h6
`define PMCC_PRESC_W 6

`endif

// ---- logic/pmcc_prescaler.v ----
// Purpose: power-of-two divider of a sampled clock level, with a ready flag
// Assumes: source level is synchronous to clock; prescale_field 0..6 divides by 1..64
// Notes: restart clears the count and the ready flag
`timescale 1ns/1ps
`include "pmcc_consts.vh"

module pmcc_prescaler (
  input wire clock, // system clock
  input wire nrst, // async reset, active low
  input wire srcLvl, // sampled source clock level
  input wire [2:0] prescale_field, // divide by 2**prescale_field
  input wire restart, // restart divider
  output reg clkOut_r, // divided clock level
  output reg rdy_r // output follows programmed setting
);

  reg srcPrev_r;
  reg [`PMCC_PRESC_W-1:0] cnt_r;
  wire srcRise;
  wire [`PMCC_PRESC_W-1:0] mask;

  function [`PMCC_PRESC_W-1:0] presMask;
    input [2:0] p;
    begin
      presMask = ~({`PMCC_PRESC_W{1'b1}} << p);
    end
  endfunction

  assign srcRise = srcLvl & ~srcPrev_r;
  assign mask = presMask(prescale_field);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      srcPrev_r <= 1'b0;
      cnt_r <= {`PMCC_PRESC_W{1'b0}};
      clkOut_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      srcPrev_r <= srcLvl;
      if (restart) begin
        cnt_r <= {`PMCC_PRESC_W{1'b0}};
        rdy_r <= 1'b0;
      end else if (srcRise) begin
        cnt_r <= cnt_r + 1'b1;
        if ((cnt_r & mask) == mask)
          rdy_r <= 1'b1;
      end
      // bit prescale_field-1 of the edge count toggles at source / 2**prescale_field
      if (prescale_field == 3'h0)
        clkOut_r <= srcLvl;
      else
        clkOut_r <= cnt_r[prescale_field - 3'h1];
    end
  end

endmodule // pmcc_prescaler

// ---- logic/pmcc_downcounter.v ----
// Purpose: loadable down counter that raises a done flag at its end
// Assumes: tick is a one-cycle pulse
// Notes: a load of N gives done after N ticks, 0 after the first tick
`timescale 1ns/1ps
`include "pmcc_consts.vh"

module pmcc_downcounter #(
  parameter W = 8 // counter width
) (
  input wire clock, // system clock
  input wire nrst, // async reset, active low
  input wire load, // start counting from loadVal
  input wire [W-1:0] loadVal, // start value
  input wire tick, // count pulse
  input wire abort, // stop and clear done
  output reg done_r // count has run out
);

  reg [W-1:0] cnt_r;
  reg run_r;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= {W{1'b0}};
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else if (abort) begin
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else if (load) begin
      cnt_r <= loadVal;
      run_r <= 1'b1;
      done_r <= 1'b0;
    end else if (run_r && tick) begin
      if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
        run_r <= 1'b0;
        done_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule // pmcc_downcounter

// ---- logic/pmcc_clk_ctrl.v ----
// Purpose: clock selection, gating and start-up sequencing of the controller
// Assumes: source clocks arrive as levels synchronous to clock; writes are strobes
// Notes: clock outputs are registered levels of the gated, divided sources
`timescale 1ns/1ps
`include "pmcc_consts.vh"

module pmcc_clk_ctrl #(
  parameter PERIPH_N = 32, // peripheral clock count
  parameter PCK_N = 3, // programmable clock outputs
  parameter MEAS_W = 16 // frequency count width
) (
  input wire clock, // system clock, 20 MHz
  input wire nrst, // async reset, active low
  input wire slowClkIn, // sampled slow clock level
  input wire mainClkIn, // sampled main oscillator level
  input wire pllClkIn, // sampled PLL output level
  input wire mckrWr, // master clock register write strobe
  input wire [1:0] mckrCss, // master source select
  input wire [2:0] mckrPres, // master prescale code
  input wire scerWr, // system clock enable write strobe
  input wire scdrWr, // system clock disable write strobe
  input wire [`PMCC_SYS_W-1:0] sysData, // system clock write data
  input wire pcerWr, // peripheral enable write strobe
  input wire pcdrWr, // peripheral disable write strobe
  input wire [PERIPH_N-1:0] periphData, // peripheral write data
  input wire [PCK_N-1:0] pckWr, // programmable clock register write strobes
  input wire [1:0] pckCss, // programmable source select
  input wire [2:0] pckPres, // programmable prescale code
  input wire morWr, // main oscillator register write strobe
  input wire oscEnable, // oscillator enable bit
  input wire [7:0] oscStartupCount, // start-up count
  input wire pllrWr, // PLL register write strobe
  input wire [7:0] pllDivide, // PLL input divider
  input wire [10:0] pllMultiplier, // PLL multiplier
  input wire [5:0] pllSettleCount, // lock wait in slow cycles
  input wire [1:0] usbDivider, // USB divider code
  input wire irqWake, // enabled fast or normal interrupt pending
  input wire instrDone, // processor finishing its current instruction
  output reg masterClk_r, // master clock
  output reg processorClk_r, // processor clock
  output reg usbDeviceClk_r, // USB device clock
  output reg [PERIPH_N-1:0] periphClk_r, // peripheral clocks
  output reg [PCK_N-1:0] progClkOut_r, // programmable clock pins
  output wire [`PMCC_SYS_W-1:0] sysClkStatus, // system clock status word
  output reg [PERIPH_N-1:0] periphEn_r, // peripheral clock status
  output reg masterReady_r, // master clock ready flag
  output wire oscStable, // oscillator stable flag
  output wire pllLock, // PLL lock flag
  output reg [PCK_N-1:0] pckReady_r, // programmable clock ready flags
  output reg freqMeasReady_r, // frequency measurement ready
  output reg [MEAS_W-1:0] freqMeasCount_r, // main cycles in window
  output reg oscOn_r, // oscillator power enable
  output reg [7:0] pllDiv_r, // PLL divider setting
  output reg [10:0] pllMul_r, // PLL multiplier setting
  output wire pllOn // PLL running
);

  localparam MS_IDLE = 3'h1;
  localparam MS_ARM = 3'h2;
  localparam MS_COUNT = 3'h4;

  reg [1:0] mCss_r;
  reg [2:0] mPres_r;
  reg procEn_r;
  reg stopPending_r;
  reg usbEn_r;
  reg [PCK_N-1:0] pckEn_r;
  reg [2*PCK_N-1:0] pckCss_r;
  reg [3*PCK_N-1:0] pckPres_r;
  reg [1:0] usb_divider_field_r;
  reg slowPrev_r;
  reg mainPrev_r;
  reg [2:0] oscPre_r;
  reg [2:0] measState_r;
  reg [2:0] measState_nxt;
  reg [4:0] measFalls_r;
  reg masterReady_nxt;
  wire slowRise;
  wire slowFall;
  wire mainRise;
  wire oscTick;
  wire pllCfgOn;
  wire [1:0] mSrcSel;
  wire mPresClk;
  wire mPresRdy;
  wire usbPresClk;
  wire [PCK_N-1:0] pckPresClk;
  wire [PCK_N-1:0] pckPresRdy;
  wire [PERIPH_N-1:0] periphEn_nxt;
  wire pllGated;

  // source multiplexer shared by master and programmable clocks
  function srcPick;
    input [1:0] clk_source_select;
    input s;
    input m;
    input p;
    begin
      case (clk_source_select)
        `PMCC_CSS_MAIN: srcPick = m;
        `PMCC_CSS_PLL: srcPick = p;
        default: srcPick = s;
      endcase
    end
  endfunction

  assign slowRise = slowClkIn & ~slowPrev_r;
  assign slowFall = ~slowClkIn & slowPrev_r;
  assign mainRise = mainClkIn & ~mainPrev_r;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slowPrev_r <= 1'b0;
      mainPrev_r <= 1'b0;
    end else begin
      slowPrev_r <= slowClkIn;
      mainPrev_r <= mainClkIn;
    end
  end

  // main oscillator: start-up counted at slow clock / 8
  assign oscTick = slowRise & (oscPre_r == `PMCC_OSC_PRE_LAST);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oscOn_r <= 1'b0;
      oscPre_r <= 3'h0;
    end else begin
      if (morWr)
        oscOn_r <= oscEnable;
      if (morWr && oscEnable)
        oscPre_r <= 3'h0;
      else if (slowRise)
        oscPre_r <= oscPre_r + 3'h1;
    end
  end

  pmcc_downcounter #(.W(8)) uOscCnt (
    .clock(clock),
    .nrst(nrst),
    .load(morWr & oscEnable),
    .loadVal(oscStartupCount),
    .tick(oscTick),
    .abort(morWr & ~oscEnable),
    .done_r(oscStable)
  );

  // frequency measurement: starts on slow rise after stable, ends at 16th fall
  always @* begin
    measState_nxt = measState_r;
    case (measState_r)
      MS_IDLE: if (oscStable && !freqMeasReady_r) measState_nxt = MS_ARM;
      MS_ARM: if (slowRise) measState_nxt = MS_COUNT;
      MS_COUNT: if (slowFall && measFalls_r == `PMCC_MEAS_PERIODS - 5'h1) measState_nxt = MS_IDLE;
      default: measState_nxt = MS_IDLE;
    endcase
    if (!oscStable)
      measState_nxt = MS_IDLE;
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      measState_r <= MS_IDLE;
      measFalls_r <= 5'h0;
      freqMeasCount_r <= {MEAS_W{1'b0}};
      freqMeasReady_r <= 1'b0;
    end else begin
      measState_r <= measState_nxt;
      if (!oscStable)
        freqMeasReady_r <= 1'b0;
      else if (measState_r == MS_COUNT && measState_nxt == MS_IDLE)
        freqMeasReady_r <= 1'b1;
      if (measState_r == MS_ARM) begin
        measFalls_r <= 5'h0;
        freqMeasCount_r <= {MEAS_W{1'b0}};
      end else if (measState_r == MS_COUNT) begin
        if (mainRise)
          freqMeasCount_r <= freqMeasCount_r + 1'b1;
        if (slowFall)
          measFalls_r <= measFalls_r + 5'h1;
      end
    end
  end

  // PLL divider and multiplier; zero in either turns the PLL off
  assign pllCfgOn = (pllDivide != `PMCC_DIV_RST) && (pllMultiplier != `PMCC_MUL_RST);
  assign pllOn = (pllDiv_r != `PMCC_DIV_RST) && (pllMul_r != `PMCC_MUL_RST);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pllDiv_r <= `PMCC_DIV_RST;
      pllMul_r <= `PMCC_MUL_RST;
      usb_divider_field_r <= `PMCC_USB_DIVIDER_FIELD_RST;
    end else if (pllrWr) begin
      pllDiv_r <= pllDivide;
      pllMul_r <= pllMultiplier;
      usb_divider_field_r <= usbDivider;
    end
  end

  // every write with the PLL on restarts the settle count and drops lock
  pmcc_downcounter #(.W(6)) uPllCnt (
    .clock(clock),
    .nrst(nrst),
    .load(pllrWr & pllCfgOn),
    .loadVal(pllSettleCount),
    .tick(slowRise),
    .abort(pllrWr & ~pllCfgOn),
    .done_r(pllLock)
  );

  assign pllGated = pllClkIn & pllLock;

  // master clock: selector then prescaler; PLL falls back to main while unlocked
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mCss_r <= `PMCC_CSS_RST;
      mPres_r <= `PMCC_PRESCALE_FIELD_RST;
    end else if (mckrWr) begin
      mCss_r <= mckrCss;
      mPres_r <= (mckrPres > `PMCC_PRESCALE_FIELD_MAX) ? `PMCC_PRESCALE_FIELD_MAX : mckrPres;
    end
  end

  assign mSrcSel = (mCss_r == `PMCC_CSS_PLL && !pllLock) ? `PMCC_CSS_MAIN : mCss_r;

  pmcc_prescaler uMasterPres (
    .clock(clock),
    .nrst(nrst),
    .srcLvl(srcPick(mSrcSel, slowClkIn, mainClkIn, pllGated)),
    .prescale_field(mPres_r),
    .restart(mckrWr),
    .clkOut_r(mPresClk),
    .rdy_r(mPresRdy)
  );

  always @* begin
    masterReady_nxt = masterReady_r;
    if (mckrWr)
      masterReady_nxt = 1'b0;
    else if (mCss_r == `PMCC_CSS_PLL && !pllLock)
      masterReady_nxt = 1'b0;
    else if (mPresRdy)
      masterReady_nxt = 1'b1;
  end

  // processor clock: idle stop waits for instruction end, wake on interrupt
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      procEn_r <= 1'b1;
      stopPending_r <= 1'b0;
    end else if ((scerWr && sysData[`PMCC_SYS_PROC]) || irqWake) begin
      procEn_r <= 1'b1;
      stopPending_r <= 1'b0;
    end else if (scdrWr && sysData[`PMCC_SYS_PROC]) begin
      stopPending_r <= 1'b1;
    end else if (stopPending_r && instrDone) begin
      procEn_r <= 1'b0;
      stopPending_r <= 1'b0;
    end
  end

  // USB device clock and programmable clock enables; zero bits have no effect
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      usbEn_r <= 1'b0;
      pckEn_r <= {PCK_N{1'b0}};
    end else begin
      if (scerWr && sysData[`PMCC_SYS_USB])
        usbEn_r <= 1'b1;
      else if (scdrWr && sysData[`PMCC_SYS_USB])
        usbEn_r <= 1'b0;
      if (scerWr)
        pckEn_r <= pckEn_r | sysData[`PMCC_SYS_PCK0 +: PCK_N];
      else if (scdrWr)
        pckEn_r <= pckEn_r & ~sysData[`PMCC_SYS_PCK0 +: PCK_N];
    end
  end

  assign sysClkStatus = {pckEn_r, usbEn_r, 6'h00, procEn_r};

  pmcc_prescaler uUsbPres (
    .clock(clock),
    .nrst(nrst),
    .srcLvl(pllGated),
    .prescale_field({1'b0, usb_divider_field_r}),
    .restart(pllrWr),
    .clkOut_r(usbPresClk),
    .rdy_r()
  );

  // peripheral clocks: bit i gates peripheral identifier i
  assign periphEn_nxt = pcerWr ? (periphEn_r | periphData) :
                        pcdrWr ? (periphEn_r & ~periphData) : periphEn_r;

  // programmable clock outputs, one prescaler each
  genvar gi;
  generate
    for (gi = 0; gi < PCK_N; gi = gi + 1) begin : gPck
      always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          pckCss_r[2*gi +: 2] <= `PMCC_CSS_RST;
          pckPres_r[3*gi +: 3] <= `PMCC_PRESCALE_FIELD_RST;
        end else if (pckWr[gi]) begin
          pckCss_r[2*gi +: 2] <= pckCss;
          pckPres_r[3*gi +: 3] <= (pckPres > `PMCC_PRESCALE_FIELD_MAX) ? `PMCC_PRESCALE_FIELD_MAX : pckPres;
        end
      end

      pmcc_prescaler uPckPres (
        .clock(clock),
        .nrst(nrst),
        .srcLvl(srcPick(pckCss_r[2*gi +: 2], slowClkIn, mainClkIn, pllGated)),
        .prescale_field(pckPres_r[3*gi +: 3]),
        .restart(pckWr[gi] | ~pckEn_r[gi]),
        .clkOut_r(pckPresClk[gi]),
        .rdy_r(pckPresRdy[gi])
      );
    end
  endgenerate

  // registered gated clock outputs and ready flags
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      masterClk_r <= 1'b0;
      processorClk_r <= 1'b0;
      usbDeviceClk_r <= 1'b0;
      periphClk_r <= {PERIPH_N{1'b0}};
      periphEn_r <= {PERIPH_N{1'b0}};
      progClkOut_r <= {PCK_N{1'b0}};
      pckReady_r <= {PCK_N{1'b0}};
      masterReady_r <= 1'b0;
    end else begin
      masterReady_r <= masterReady_nxt;
      masterClk_r <= mPresClk;
      processorClk_r <= mPresClk & procEn_r;
      usbDeviceClk_r <= usbPresClk & usbEn_r;
      periphEn_r <= periphEn_nxt;
      periphClk_r <= {PERIPH_N{mPresClk}} & periphEn_nxt;
      progClkOut_r <= pckPresClk & pckEn_r;
      // a disable write drops ready in the same cycle as the status bit
      pckReady_r <= pckPresRdy & pckEn_r & ~pckWr &
                    ~({PCK_N{scdrWr & ~scerWr}} & sysData[`PMCC_SYS_PCK0 +: PCK_N]);
    end
  end

endmodule // pmcc_clk_ctrl

// ---- dv/pmcc_clk_ctrl_sva.sv ----
// Purpose: concurrent checks on the ports of the clock controller
// Assumes: bound to pmcc_clk_ctrl; one clock domain, reset async active low
// Notes: windows follow the hand-over timing of writes and flags
`timescale 1ns/1ps
`include "pmcc_consts.vh"

module pmcc_clk_ctrl_sva #(
  parameter PERIPH_N = 32 // peripheral clock count
) (
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic mckrWr, // master write strobe
  input wire logic pcerWr, // peripheral enable strobe
  input wire logic pcdrWr, // peripheral disable strobe
  input wire logic [PERIPH_N-1:0] periphData, // peripheral write data
  input wire logic morWr, // oscillator write strobe
  input wire logic pllrWr, // PLL write strobe
  input wire logic [7:0] pllDivide, // PLL divider data
  input wire logic [10:0] pllMultiplier, // PLL multiplier data
  input wire logic irqWake, // wake request
  input wire logic instrDone, // instruction end
  input wire logic usbDeviceClk_r, // USB clock
  input wire logic [PERIPH_N-1:0] periphClk_r, // peripheral clocks
  input wire logic [`PMCC_SYS_W-1:0] sysClkStatus, // system status word
  input wire logic [PERIPH_N-1:0] periphEn_r, // peripheral status
  input wire logic masterReady_r, // master ready flag
  input wire logic oscStable, // oscillator stable flag
  input wire logic pllLock, // lock flag
  input wire logic [2:0] pckReady_r, // programmable ready flags
  input wire logic pllOn // PLL running
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_pcer_sets: assert property (pcerWr |=> (periphEn_r & $past(periphData)) == $past(periphData))
    else $error("peripheral enable write did not set status");
  a_pcdr_stops: assert property (pcdrWr && !pcerWr |=> ((periphEn_r | periphClk_r) & $past(periphData)) == 0)
    else $error("peripheral disable did not stop clock at once");
  a_zero_keeps: assert property (!pcerWr && !pcdrWr |=> periphEn_r == $past(periphEn_r))
    else $error("peripheral status changed without a write");
  a_periph_gated: assert property ((periphClk_r & ~periphEn_r) == 0)
    else $error("peripheral clock runs while disabled");
  a_wake_restart: assert property (irqWake |-> ##[1:3] sysClkStatus[`PMCC_SYS_PROC])
    else $error("wake did not restart processor clock");
  a_stop_waits: assert property ($fell(sysClkStatus[`PMCC_SYS_PROC]) |-> $past(instrDone) || $past(instrDone, 2))
    else $error("processor clock stopped mid instruction");
  a_mck_clear: assert property (mckrWr |=> !masterReady_r)
    else $error("master write did not clear ready");
  a_osc_clear: assert property (morWr |=> !oscStable)
    else $error("oscillator write did not clear stable");
  a_pll_clear: assert property (pllrWr && pllDivide != 0 && pllMultiplier != 0 |=> !pllLock)
    else $error("PLL write did not drop lock");
  a_pll_off: assert property (!pllOn [*2] |-> !pllLock)
    else $error("lock shown while PLL off");
  a_pck_ready: assert property (pckReady_r[0] |-> sysClkStatus[`PMCC_SYS_PCK0])
    else $error("programmable ready while disabled");
  a_usb_lock: assert property (!pllLock [*3] |-> !usbDeviceClk_r)
    else $error("USB clock runs without lock");

  c_pdis: cover property (pcdrWr ##1 !periphClk_r[4]);
  c_lock: cover property ($rose(pllLock));
  c_osc: cover property ($rose(oscStable));
endmodule // pmcc_clk_ctrl_sva

bind pmcc_clk_ctrl pmcc_clk_ctrl_sva #(.PERIPH_N(PERIPH_N)) i_pmcc_clk_ctrl_sva (.clock(clock), .nrst(nrst),
  .mckrWr(mckrWr), .pcerWr(pcerWr), .pcdrWr(pcdrWr), .periphData(periphData), .morWr(morWr),
  .pllrWr(pllrWr), .pllDivide(pllDivide), .pllMultiplier(pllMultiplier), .irqWake(irqWake),
  .instrDone(instrDone), .usbDeviceClk_r(usbDeviceClk_r), .periphClk_r(periphClk_r),
  .sysClkStatus(sysClkStatus), .periphEn_r(periphEn_r), .masterReady_r(masterReady_r),
  .oscStable(oscStable), .pllLock(pllLock), .pckReady_r(pckReady_r), .pllOn(pllOn));

// ---- dv/test_pmcc_clk_ctrl.sv ----
// Purpose: self-checking bench of the clock controller
// Assumes: inputs change at falling edges; slow/main/PLL levels made here
// Notes: slow period 8 cycles, main 4, PLL 2
`timescale 1ns/1ps
`include "pmcc_consts.vh"

module test_pmcc_clk_ctrl;
  logic clock = 0, nrst = 0, slowClkIn = 0, mainClkIn = 0, pllClkIn = 0;
  logic [9:0] stb = 0;
  logic [1:0] clk_source_select = 0, usbDivider = 0;
  logic [2:0] prescale_field = 0;
  logic [10:0] sysData = 0, pllMultiplier = 0;
  logic [31:0] periphData = 0;
  logic oscEnable = 0, irqWake = 0, instrDone = 0;
  logic [7:0] oscStartupCount = 0, pllDivide = 0;
  logic [5:0] pllSettleCount = 0;
  logic [3:0] srcCnt = 0;
  wire masterClk_r, processorClk_r, usbDeviceClk_r, masterReady_r, oscStable, pllLock, freqMeasReady_r;
  wire oscOn_r, pllOn;
  wire [31:0] periphClk_r, periphEn_r;
  wire [2:0] progClkOut_r, pckReady_r;
  wire [10:0] sysClkStatus, pllMul_r;
  wire [15:0] freqMeasCount_r;
  wire [7:0] pllDiv_r;
  wire [6:0] flags = {pckReady_r, freqMeasReady_r, masterReady_r, oscStable, pllLock};
  wire [4:0] probe = {usbDeviceClk_r, progClkOut_r, masterClk_r};
  int n_fail = 0, samples_checked = 0;
  int srcPer[3] = '{8, 4, 2};
  logic [1:0] cssCode[3] = '{2'h0, 2'h1, 2'h3};

  pmcc_clk_ctrl i_pmcc_clk_ctrl (.clock(clock), .nrst(nrst), .slowClkIn(slowClkIn), .mainClkIn(mainClkIn),
    .pllClkIn(pllClkIn), .mckrWr(stb[4]), .mckrCss(clk_source_select), .mckrPres(prescale_field), .scerWr(stb[0]), .scdrWr(stb[1]),
    .sysData(sysData), .pcerWr(stb[2]), .pcdrWr(stb[3]), .periphData(periphData), .pckWr(stb[9:7]),
    .pckCss(clk_source_select), .pckPres(prescale_field), .morWr(stb[5]), .oscEnable(oscEnable), .oscStartupCount(oscStartupCount),
    .pllrWr(stb[6]), .pllDivide(pllDivide), .pllMultiplier(pllMultiplier), .pllSettleCount(pllSettleCount),
    .usbDivider(usbDivider), .irqWake(irqWake), .instrDone(instrDone), .masterClk_r(masterClk_r),
    .processorClk_r(processorClk_r), .usbDeviceClk_r(usbDeviceClk_r), .periphClk_r(periphClk_r),
    .progClkOut_r(progClkOut_r), .sysClkStatus(sysClkStatus), .periphEn_r(periphEn_r),
    .masterReady_r(masterReady_r), .oscStable(oscStable), .pllLock(pllLock), .pckReady_r(pckReady_r),
    .freqMeasReady_r(freqMeasReady_r), .freqMeasCount_r(freqMeasCount_r), .oscOn_r(oscOn_r),
    .pllDiv_r(pllDiv_r), .pllMul_r(pllMul_r), .pllOn(pllOn));

  always #25 clock = ~clock;

  always @(negedge clock) begin
    srcCnt <= srcCnt + 4'h1;
    pllClkIn <= srcCnt[0];
    mainClkIn <= srcCnt[1];
    slowClkIn <= srcCnt[2];
  end

  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_range(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("MISMATCH t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  // one-cycle write strobe, data already set; a quiet cycle follows
  task pulse(input int s);
    stb[s] = 1'b1;
    @(negedge clock);
    stb[s] = 1'b0;
    @(negedge clock);
  endtask

  task wait_flag(input int i, input int lim);
    int k;
    k = 0;
    while (flags[i] !== 1'b1 && k < lim) begin
      @(negedge clock);
      k++;
    end
    if (flags[i] !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t flag %0d never set", $time, i);
      close_out();
    end
  endtask

  // cycles from one rising edge of a clock output to the next
  task period(input int idx, input int exp);
    int k, p;
    k = 0;
    p = 0;
    while (probe[idx] !== 1'b0 && k < 300) begin @(negedge clock); k++; end
    while (probe[idx] !== 1'b1 && k < 300) begin @(negedge clock); k++; end
    while (probe[idx] !== 1'b0 && k < 300) begin @(negedge clock); k++; p++; end
    while (probe[idx] !== 1'b1 && k < 300) begin @(negedge clock); k++; p++; end
    if (k >= 300) begin
      n_fail++;
      $display("MISMATCH t=%0t output %0d not toggling", $time, idx);
      close_out();
    end
    chk(p, exp);
  endtask

  initial begin
    tick(5);
    nrst = 1'b1;
    chk(sysClkStatus, 32'h001);
    chk(periphEn_r, 32'h0);
    periphData = 32'h0000_0110;
    pulse(2);
    chk(periphEn_r, 32'h110);
    chk(periphClk_r & ~32'h110, 32'h0);
    periphData = 32'h0000_0010;
    pulse(3);
    chk(periphEn_r, 32'h100);
    chk(periphClk_r[4], 1'b0);
    periphData = 32'h0;
    pulse(2);
    pulse(3);
    chk(periphEn_r, 32'h100);
    sysData = 11'h001;
    pulse(1);
    tick(4);
    chk(sysClkStatus[0], 1'b1);
    instrDone = 1'b1;
    tick(3);
    chk({processorClk_r, sysClkStatus[0]}, 2'b00);
    instrDone = 1'b0;
    irqWake = 1'b1;
    tick(3);
    chk(sysClkStatus[0], 1'b1);
    irqWake = 1'b0;
    oscEnable = 1'b1;
    oscStartupCount = 8'h02;
    pulse(5);
    chk({oscOn_r, oscStable}, 2'b10);
    tick(96);
    chk(oscStable, 1'b0);
    wait_flag(1, 48);
    wait_flag(3, 300);
    chk_range(freqMeasCount_r, 31, 33);
    for (int m = 0; m < 2; m++) begin
      clk_source_select = cssCode[m];
      prescale_field = 3'(1 - m);
      pulse(4);
      chk(masterReady_r, 1'b0);
      wait_flag(2, 200);
      period(0, srcPer[m] << (1 - m));
    end
    pllDivide = 8'h01;
    pllMultiplier = 11'h004;
    pllSettleCount = 6'h08;
    sysData = 11'h080;
    pulse(0);
    chk(sysClkStatus[7], 1'b1);
    for (int u = 0; u < 3; u++) begin
      usbDivider = 2'(u);
      pulse(6);
      chk(pllLock, 1'b0);
      tick(48);
      chk(pllLock, 1'b0);
      wait_flag(0, 40);
      period(4, 2 << u);
    end
    // programmable outputs run while the PLL is locked, so the PLL source toggles
    for (int i = 0; i < 3; i++) begin
      clk_source_select = cssCode[i];
      prescale_field = 3'(2 * i);
      pulse(7 + i);
      sysData = 11'h1 << (8 + i);
      pulse(0);
      chk(sysClkStatus[8 + i], 1'b1);
      wait_flag(4 + i, 600);
      period(1 + i, srcPer[i] << (2 * i));
      pulse(1);
      chk({pckReady_r[i], sysClkStatus[8 + i]}, 2'b00);
    end
    chk({pllOn, pllDiv_r, pllMul_r}, {1'b1, 8'h01, 11'h004});
    pllDivide = 8'hff;
    pllMultiplier = 11'h7ff;
    pulse(6);
    chk({pllOn, pllDiv_r, pllMul_r}, {1'b1, 8'hff, 11'h7ff});
    pllMultiplier = 11'h000;
    pulse(6);
    tick(2);
    chk({pllOn, pllLock}, 2'b00);
    pllDivide = 8'h00;
    pllMultiplier = 11'h004;
    pulse(6);
    tick(2);
    chk({pllOn, pllLock}, 2'b00);
    oscEnable = 1'b0;
    pulse(5);
    tick(2);
    chk({oscOn_r, oscStable, freqMeasReady_r}, 3'b000);
    close_out();
  end
endmodule // test_pmcc_clk_ctrl
